/* File: core/sdp_core.sv */
// sdp_core: four-bank byte-wide sdram device logic behind its pins
`timescale 1ns/100ps
module sdp_core (
  input logic clk,
  input logic reset_n,
  input sdp_pkg::sdp_cmd_pins_t cmd_pins,
  input logic clock_gate_enable,
  input logic data_mask,
  input logic [sdp_pkg::DATA_W-1:0] data_io_bus_in,
  output logic [sdp_pkg::DATA_W-1:0] data_io_bus_out,
  output logic data_io_bus_oe,
  output logic [sdp_pkg::NUM_BANKS-1:0] bank_open,
  output sdp_pkg::sdp_pwr_t power_mode,
  output logic [sdp_pkg::ROW_W-1:0] mode_word,
  output logic cmd_illegal
);
  import sdp_pkg::*;

  // internal clock gate, one edge behind the pin
  logic cke_prev;
  logic clk_run;

  // decoded command
  sdp_cmd_t cmd_raw;
  sdp_cmd_t cmd;
  logic [BANK_W-1:0] cmd_bank;
  logic [ROW_W-1:0] cmd_addr;
  logic prech_mode;

  // bank state
  logic [ROW_W-1:0] bank_row [NUM_BANKS];
  logic sel_open;
  logic all_idle;

  // accepted commands
  logic rd_go;
  logic wr_go;
  logic act_go;
  logic pre_go;
  logic mrs_go;
  logic [2:0] rd_len;
  logic [2:0] wr_len;

  // burst engine
  logic bst_rd;
  logic bst_wr;
  logic bst_busy;
  logic bst_ap;
  logic [BANK_W-1:0] bst_bank;
  logic [ROW_W-1:0] bst_row;
  logic [COL_W-1:0] bst_start;
  logic [COL_W-1:0] bst_beat;
  logic [2:0] bst_len;
  logic [COL_W-1:0] bst_col;
  logic bst_last;
  logic bst_stop;

  // auto precharge request
  logic ap_fire;
  logic [BANK_W-1:0] ap_bank;

  // storage and read pipe
  logic [DATA_W-1:0] mem [2**MEM_AW];
  logic [MEM_AW-1:0] wr_addr;
  logic [MEM_AW-1:0] rd_addr;
  logic wr_do;
  logic [DATA_W-1:0] rd_q;
  logic rd_v1;
  logic dqm_d1;
  logic dqm_d2;

  // pin capture happens on the rising edge only, clk is the
  // controller's own clock so no synchroniser is needed
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cke_prev <= 1'b1;
    end else begin
      cke_prev <= clock_gate_enable;
    end
  end

  // the internal clock runs when the gate was high one edge before
  assign clk_run = cke_prev;

  sdp_cmd_decode u_decode (
    .pins(cmd_pins),
    .cmd(cmd_raw)
  );

  // a frozen internal clock sees no commands at all
  assign cmd = clk_run ? cmd_raw : CMD_NOP;
  assign cmd_bank = cmd_pins.bank_select;
  assign cmd_addr = cmd_pins.address;
  assign prech_mode = cmd_addr[PRECH_MODE_BIT];

  // bank readiness
  assign sel_open = bank_open[cmd_bank];
  assign bst_busy = bst_rd || bst_wr;
  assign all_idle = (bank_open == '0) && !bst_busy;

  // read and write need an open row, otherwise they do nothing
  assign rd_go = (cmd == CMD_READ) && sel_open;
  assign wr_go = (cmd == CMD_WRITE) && sel_open;
  assign act_go = (cmd == CMD_ACTIVATE) && !sel_open;
  assign pre_go = (cmd == CMD_PRECHARGE);
  assign mrs_go = (cmd == CMD_MRS) && all_idle;

  // burst lengths; single-write mode forces writes to one beat
  assign rd_len = mode_word[MODE_LEN_LSB +: MODE_LEN_W];
  assign wr_len = mode_word[MODE_WSINGLE_BIT] ? LEN_1 : rd_len;

  // mode word, only writable with every bank closed
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_word <= MODE_RESET;
    end else if (mrs_go) begin
      mode_word <= cmd_addr;
    end
  end

  // power state as seen on the gate transitions
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      power_mode <= PWR_RUN;
    end else if (cke_prev && !clock_gate_enable) begin
      // entry decided by the command on the falling gate edge
      if (cmd_raw == CMD_REFRESH && all_idle) begin
        power_mode <= PWR_SELF;
      end else if (cmd_raw == CMD_NOP && all_idle) begin
        power_mode <= PWR_DOWN;
      end else begin
        power_mode <= PWR_SUSPEND;
      end
    end else if (!cke_prev && clock_gate_enable) begin
      power_mode <= PWR_RUN;
    end
  end

  // per-bank open flag and row latch
  for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank
    logic hit;
    logic pre_hit;
    assign hit = (cmd_bank == BANK_W'(g));
    // all-bank precharge ignores the bank select lines
    assign pre_hit = pre_go && (prech_mode || hit);

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        bank_open[g] <= 1'b0;
        bank_row[g] <= '0;
      end else if (act_go && hit) begin
        bank_open[g] <= 1'b1;
        bank_row[g] <= cmd_addr;
      end else if (pre_hit) begin
        bank_open[g] <= 1'b0;
      end else if (ap_fire && ap_bank == BANK_W'(g)) begin
        bank_open[g] <= 1'b0;
      end
    end
  end

  // column of the current beat
  sdp_burst_addr u_baddr (
    .len_code(bst_len),
    .interleave(mode_word[MODE_ORDER_BIT]),
    .start(bst_start),
    .beat(bst_beat),
    .col(bst_col),
    .last(bst_last)
  );

  // terminate, or a precharge that hits the bursting bank, ends it
  assign bst_stop = (cmd == CMD_TERMINATE) ||
                    (pre_go && (prech_mode || cmd_bank == bst_bank));

  // burst tracking, one beat per running edge with no gaps
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bst_rd <= 1'b0;
      bst_wr <= 1'b0;
      bst_ap <= 1'b0;
      bst_bank <= '0;
      bst_row <= '0;
      bst_start <= '0;
      bst_beat <= '0;
      bst_len <= LEN_1;
    end else if (clk_run) begin
      if (rd_go) begin
        // read beat 0 is fetched on the next edge
        bst_rd <= 1'b1;
        bst_wr <= 1'b0;
        bst_ap <= prech_mode;
        bst_bank <= cmd_bank;
        bst_row <= bank_row[cmd_bank];
        bst_start <= cmd_addr[COL_W-1:0];
        bst_beat <= '0;
        bst_len <= rd_len;
      end else if (wr_go) begin
        // write beat 0 is stored on this edge, so carry on at beat 1
        bst_rd <= 1'b0;
        bst_wr <= (wr_len != LEN_1);
        bst_ap <= prech_mode;
        bst_bank <= cmd_bank;
        bst_row <= bank_row[cmd_bank];
        bst_start <= cmd_addr[COL_W-1:0];
        bst_beat <= 8'h01;
        bst_len <= wr_len;
      end else if (bst_stop) begin
        bst_rd <= 1'b0;
        bst_wr <= 1'b0;
      end else if (bst_busy) begin
        if (bst_last) begin
          bst_rd <= 1'b0;
          bst_wr <= 1'b0;
        end else begin
          bst_beat <= bst_beat + 8'h01;
        end
      end
    end
  end

  // auto precharge at the natural end of a burst; a single-beat
  // write ends on its own command edge
  always_comb begin
    ap_fire = 1'b0;
    ap_bank = bst_bank;
    if (wr_go && wr_len == LEN_1) begin
      ap_fire = prech_mode;
      ap_bank = cmd_bank;
    end else if (clk_run && bst_busy && bst_last && bst_ap && !rd_go && !wr_go && !bst_stop) begin
      ap_fire = 1'b1;
    end
  end

  // array addressing: command beat for a fresh write, engine otherwise
  assign wr_addr = wr_go ? {cmd_bank, bank_row[cmd_bank], cmd_addr[COL_W-1:0]}
                         : {bst_bank, bst_row, bst_col};
  assign rd_addr = {bst_bank, bst_row, bst_col};
  assign wr_do = clk_run && (wr_go || (bst_wr && !rd_go && !bst_stop));

  // storage; the array carries no reset, like a real cell array
  always_ff @(posedge clk) begin
    if (wr_do && !data_mask) begin
      mem[wr_addr] <= data_io_bus_in;
    end
    if (clk_run) begin
      rd_q <= mem[rd_addr];
    end
  end

  // data mask delay line; mask is sampled even while deselected
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dqm_d1 <= 1'b0;
      dqm_d2 <= 1'b0;
    end else if (clk_run) begin
      dqm_d1 <= data_mask;
      dqm_d2 <= dqm_d1;
    end
  end

  // first read stage follows the engine; stops with it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_v1 <= 1'b0;
    end else if (clk_run) begin
      rd_v1 <= bst_rd;
    end
  end

  // output stage: data two edges after the read command; a frozen
  // clock holds the pins, which stretches the burst
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_io_bus_out <= '0;
      data_io_bus_oe <= 1'b0;
    end else if (clk_run) begin
      data_io_bus_out <= rd_q;
      // pins drive only for read beats, and the mask seen two
      // edges ago floats them
      data_io_bus_oe <= rd_v1 && !dqm_d2;
    end
  end

  // illegal command flag: access to a closed bank, activate of an
  // open bank, mode write with a bank open; one running edge wide
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_illegal <= 1'b0;
    end else if (clk_run) begin
      cmd_illegal <= ((cmd == CMD_READ || cmd == CMD_WRITE) && !sel_open) ||
                     ((cmd == CMD_ACTIVATE) && sel_open) ||
                     ((cmd == CMD_MRS) && !all_idle);
    end else begin
      cmd_illegal <= 1'b0;
    end
  end

  // refresh needs no logic here: the array is static, so refresh
  // and self-refresh only steer the power state above
endmodule : sdp_core

/* File: core/sdp_pkg.sv */
// sdp_pkg: constants and carrier types of the sdram command and data port
// Behaviour
// - every input is captured on the rising clock edge only
// - clock gate enable low stops the internal clock: power-down, suspend or self-refresh
// - deselected device ignores all inputs except clock, clock gate enable and data mask
// - row, column and write strobes, active low, encode the command each edge
// - two bank select lines choose one of four banks with the command
// - bank activate latches all twelve address lines as that bank's row
// - read or write takes the low eight address lines as column
// - precharge mode bit high on read or write closes the bank after the burst
// - precharge with precharge mode bit high closes every bank, bank select ignored
// - precharge with precharge mode bit low closes only the selected bank
// - data mask high during reads floats the outputs two cycles later
// - data mask high during writes drops that byte at once
// - burst length 1, 2, 4, 8 or full page; sequential or interleaved order
// - a mode with burst reads and single-location writes
// - read data appears two cycles after the read command
// - controller drives data pins only on writes, memory only on read bursts
// - one data transfer every burst cycle, no gaps
// - clock gate enable changes act one clock later
package sdp_pkg;
  localparam int BANK_W = 2;
  localparam int ROW_W = 12;
  localparam int COL_W = 8;
  localparam int DATA_W = 8;
  localparam int NUM_BANKS = 4;
  localparam int MEM_AW = BANK_W + ROW_W + COL_W;
  localparam int CAS_LAT = 2;
  localparam int DQM_RD_LAT = 2;
  // mode word layout
  localparam int MODE_LEN_LSB = 0;
  localparam int MODE_LEN_W = 3;
  localparam int MODE_ORDER_BIT = 3;
  localparam int MODE_WSINGLE_BIT = 9;
  localparam int PRECH_MODE_BIT = 10;
  localparam logic [ROW_W-1:0] MODE_RESET = 12'h020;
  // burst length codes
  localparam logic [2:0] LEN_1 = 3'h0;
  localparam logic [2:0] LEN_2 = 3'h1;
  localparam logic [2:0] LEN_4 = 3'h2;
  localparam logic [2:0] LEN_8 = 3'h3;
  localparam logic [2:0] LEN_PAGE = 3'h7;
  localparam logic [COL_W-1:0] PAGE_MASK = 8'hff;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_MRS, CMD_REFRESH, CMD_PRECHARGE,
    CMD_ACTIVATE, CMD_WRITE, CMD_READ, CMD_TERMINATE
  } sdp_cmd_t;

  typedef enum logic [1:0] {PWR_RUN, PWR_SUSPEND, PWR_DOWN, PWR_SELF} sdp_pwr_t;

  typedef struct packed {
    logic device_select_n;
    logic row_strobe_n;
    logic column_strobe_n;
    logic write_strobe_n;
    logic [BANK_W-1:0] bank_select;
    logic [ROW_W-1:0] address;
  } sdp_cmd_pins_t;
endpackage : sdp_pkg

/* File: core/sdp_cmd_decode.sv */
// sdp_cmd_decode: strobe pins to command code
`timescale 1ns/100ps
module sdp_cmd_decode (
  input sdp_pkg::sdp_cmd_pins_t pins,
  output sdp_pkg::sdp_cmd_t cmd
);
  import sdp_pkg::*;

  // deselect reads as no-op, data mask is not looked at here
  always_comb begin
    cmd = CMD_NOP;
    if (!pins.device_select_n) begin
      case ({pins.row_strobe_n, pins.column_strobe_n, pins.write_strobe_n})
        3'h0: cmd = CMD_MRS;
        3'h1: cmd = CMD_REFRESH;
        3'h2: cmd = CMD_PRECHARGE;
        3'h3: cmd = CMD_ACTIVATE;
        3'h4: cmd = CMD_WRITE;
        3'h5: cmd = CMD_READ;
        3'h6: cmd = CMD_TERMINATE;
        default: cmd = CMD_NOP;
      endcase
    end
  end
endmodule : sdp_cmd_decode

/* File: core/sdp_burst_addr.sv */
// sdp_burst_addr: column of a burst beat and end-of-burst flag
`timescale 1ns/100ps
module sdp_burst_addr (
  input logic [2:0] len_code,
  input logic interleave,
  input logic [sdp_pkg::COL_W-1:0] start,
  input logic [sdp_pkg::COL_W-1:0] beat,
  output logic [sdp_pkg::COL_W-1:0] col,
  output logic last
);
  import sdp_pkg::*;

  logic [COL_W-1:0] mask;
  logic [COL_W-1:0] step;

  // wrap inside the aligned block of the burst length
  always_comb begin
    case (len_code)
      LEN_1: mask = 8'h00;
      LEN_2: mask = 8'h01;
      LEN_4: mask = 8'h03;
      LEN_8: mask = 8'h07;
      default: mask = PAGE_MASK;
    endcase
    step = interleave ? (start ^ beat) : COL_W'(start + beat);
    col = (start & ~mask) | (step & mask);
    // full page runs until stopped, it never ends on its own
    last = (beat == mask) && (len_code != LEN_PAGE);
  end
endmodule : sdp_burst_addr

/* File: test/sdp_core_props.sv */
// sdp_core_props: concurrent checks on the sdram port pins
`timescale 1ns/100ps
module sdp_core_props (
  input logic clk,
  input logic reset_n,
  input sdp_pkg::sdp_cmd_pins_t cmd_pins,
  input logic clock_gate_enable,
  input logic data_mask,
  input logic [sdp_pkg::DATA_W-1:0] data_io_bus_in,
  input logic [sdp_pkg::DATA_W-1:0] data_io_bus_out,
  input logic data_io_bus_oe,
  input logic [sdp_pkg::NUM_BANKS-1:0] bank_open,
  input sdp_pkg::sdp_pwr_t power_mode,
  input logic [sdp_pkg::ROW_W-1:0] mode_word,
  input logic cmd_illegal
);
  import sdp_pkg::*;
  logic gate_q;
  logic [1:0] bs_q;
  logic acc;
  logic [2:0] rcw;
  // previous gate sample decides whether an edge counts
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gate_q <= 1'b1;
      bs_q <= 2'h0;
    end else begin
      gate_q <= clock_gate_enable;
      bs_q <= cmd_pins.bank_select;
    end
  end
  assign acc = gate_q && !cmd_pins.device_select_n;
  assign rcw = {cmd_pins.row_strobe_n, cmd_pins.column_strobe_n, cmd_pins.write_strobe_n};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_read_data_lat: assert property (
    (acc && rcw == 3'b101 && bank_open[cmd_pins.bank_select] && !data_mask && clock_gate_enable)
    ##1 (clock_gate_enable && (cmd_pins.device_select_n || rcw == 3'b111)) |=> ##1 data_io_bus_oe)
    else $error("read data not driven after read latency");
  a_mask_floats: assert property (
    (gate_q && data_mask && clock_gate_enable) ##1 clock_gate_enable |-> ##2 !data_io_bus_oe)
    else $error("masked read beat still driven");
  a_deselect_quiet: assert property (
    (gate_q && cmd_pins.device_select_n) |=> (bank_open & ~$past(bank_open)) == 4'h0)
    else $error("bank opened while deselected");
  a_activate_opens: assert property (
    (acc && rcw == 3'b011 && !bank_open[cmd_pins.bank_select]) |=> bank_open[bs_q])
    else $error("activate did not open bank");
  a_prech_all: assert property (
    (acc && rcw == 3'b010 && cmd_pins.address[PRECH_MODE_BIT]) |=> bank_open == 4'h0)
    else $error("precharge all left a bank open");
  a_prech_one: assert property (
    (acc && rcw == 3'b010 && !cmd_pins.address[PRECH_MODE_BIT]) |=> !bank_open[bs_q])
    else $error("selected bank not precharged");
  a_closed_access: assert property (
    (acc && rcw inside {3'b100, 3'b101} && !bank_open[cmd_pins.bank_select]) |=> cmd_illegal)
    else $error("access to closed bank not flagged");
  a_gate_sleep: assert property (
    (gate_q && !clock_gate_enable) |=> power_mode != PWR_RUN)
    else $error("gate low did not leave run mode");
  a_gate_wake: assert property (
    (!gate_q && clock_gate_enable) |=> power_mode == PWR_RUN)
    else $error("gate high did not return to run");
endmodule : sdp_core_props

bind sdp_core sdp_core_props u_props (.clk(clk), .reset_n(reset_n), .cmd_pins(cmd_pins),
  .clock_gate_enable(clock_gate_enable), .data_mask(data_mask), .data_io_bus_in(data_io_bus_in),
  .data_io_bus_out(data_io_bus_out), .data_io_bus_oe(data_io_bus_oe), .bank_open(bank_open),
  .power_mode(power_mode), .mode_word(mode_word), .cmd_illegal(cmd_illegal));

/* File: test/sdp_ctl_model.sv */
// sdp_ctl_model: behavioural memory controller driving the port pins
`timescale 1ns/100ps
module sdp_ctl_model (
  input logic clk,
  output sdp_pkg::sdp_cmd_pins_t cmd_pins,
  output logic clock_gate_enable,
  output logic data_mask,
  output logic [sdp_pkg::DATA_W-1:0] wdata
);
  import sdp_pkg::*;
  // idle: deselected, gate high
  initial begin
    cmd_pins = '{1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 12'h000};
    clock_gate_enable = 1'b1;
    data_mask = 1'b0;
    wdata = 8'h00;
  end
  // one slot; at 50 ns one nop covers every spacing
  // run is far shorter than the refresh period
  task put(input logic [2:0] rcw, input logic [1:0] ba, input logic [11:0] a, input logic dm,
           input logic w, input logic [7:0] d, input logic sel_n, input logic g);
    @(posedge clk);
    #1;
    cmd_pins = '{sel_n, rcw[2], rcw[1], rcw[0], ba, a};
    clock_gate_enable = g;
    data_mask = dm;
    wdata = w ? d : ~wdata; // released bus toggles
  endtask : put
endmodule : sdp_ctl_model

/* File: test/sdp_core_tb.sv */
// sdp_core_tb: directed bench for the sdram device port
`timescale 1ns/100ps
module sdp_core_tb;
  import sdp_pkg::*;
  localparam logic [2:0] C_NOP = 3'h7;
  localparam logic [2:0] C_ACT = 3'h3;
  localparam logic [2:0] C_RD = 3'h5;
  localparam logic [2:0] C_WR = 3'h4;
  localparam logic [2:0] C_PRE = 3'h2;
  localparam logic [2:0] C_MRS = 3'h0;
  logic clk;
  logic reset_n;
  sdp_cmd_pins_t cmd_pins;
  logic clock_gate_enable;
  logic data_mask;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] dout;
  logic [DATA_W-1:0] bus;
  logic oe;
  logic [NUM_BANKS-1:0] bank_open;
  sdp_pwr_t power_mode;
  logic [ROW_W-1:0] mode_word;
  logic cmd_illegal;
  int bad_count;
  int compares;
  int n;
  int cnt;
  // shared data wire: memory drives only while oe is high
  assign bus = oe ? dout : wdata;
  sdp_ctl_model ctl (.clk(clk), .cmd_pins(cmd_pins), .clock_gate_enable(clock_gate_enable),
    .data_mask(data_mask), .wdata(wdata));
  sdp_core DUT (.clk(clk), .reset_n(reset_n), .cmd_pins(cmd_pins), .clock_gate_enable(clock_gate_enable),
    .data_mask(data_mask), .data_io_bus_in(bus), .data_io_bus_out(dout), .data_io_bus_oe(oe),
    .bank_open(bank_open), .power_mode(power_mode), .mode_word(mode_word), .cmd_illegal(cmd_illegal));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task chk(input string name, input logic [11:0] exp, input logic [11:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task op(input logic [2:0] c, input logic [1:0] b = 2'h0, input logic [11:0] a = 12'h000,
          input logic dm = 1'b0, input logic w = 1'b0, input logic [7:0] d = 8'h00,
          input logic s = 1'b0, input logic g = 1'b1);
    ctl.put(c, b, a, dm, w, d, s, g);
  endtask : op
  // four-beat read, mask raised for beat mb; ex holds beat k in byte k
  task rd(input logic [1:0] b, input logic [11:0] a, input int mb, input logic [31:0] ex);
    int i;
    op(C_RD, b, a);
    for (i = 1; i < 8; i++) begin
      op(C_NOP, 2'h0, 12'h000, i == mb);
      if (i >= 3) begin
        chk("oe", 12'((i < 7) && (i - 3 != mb)), 12'(oe));
        if (i < 7 && i - 3 != mb) chk("rdata", 12'(ex[8*(i-3) +: 8]), 12'(dout));
      end
    end
  endtask : rd
  task tally_and_finish;
    $display("compares %0d bad %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // watchdog against a hung run
  initial begin
    #1ms;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    bad_count = 0;
    compares = 0;
    reset_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 reset_n = 1'b1;
    chk("mode", 12'h020, mode_word);
    chk("open", 12'h000, 12'(bank_open));
    op(C_MRS, 2'h0, 12'h002);
    op(C_ACT, 2'h1, 12'habc);
    op(C_ACT, 2'h2, 12'h000, 1'b0, 1'b0, 8'h00, 1'b1);
    op(C_NOP);
    chk("mode", 12'h002, mode_word);
    chk("open", 12'h002, 12'(bank_open));
    // second beat masked on the way in
    op(C_WR, 2'h1, 12'h005, 1'b0, 1'b1, 8'ha0);
    op(C_NOP, 2'h0, 12'h000, 1'b1, 1'b1, 8'ha1);
    op(C_NOP, 2'h0, 12'h000, 1'b0, 1'b1, 8'ha2);
    op(C_NOP, 2'h0, 12'h000, 1'b0, 1'b1, 8'ha3);
    rd(2'h1, 12'h005, 1, 32'ha3a2_00a0);
    op(C_MRS, 2'h0, 12'h00a);
    op(C_NOP);
    chk("illegal", 12'h001, 12'(cmd_illegal));
    chk("mode", 12'h002, mode_word);
    op(C_PRE, 2'h1, 12'h000);
    op(C_MRS, 2'h0, 12'h00a);
    op(C_ACT, 2'h1, 12'habc);
    op(C_NOP);
    chk("mode", 12'h00a, mode_word);
    rd(2'h1, 12'h405, 3, 32'h00a2_a3a0);
    chk("open", 12'h000, 12'(bank_open));
    op(C_RD, 2'h1, 12'h005);
    op(C_NOP);
    chk("illegal", 12'h001, 12'(cmd_illegal));
    // burst lengths 1, 2, 4 and 8: count driven beats
    for (n = 0; n < 4; n++) begin
      op(C_PRE, 2'h0, 12'h400);
      op(C_MRS, 2'h0, 12'(n));
      op(C_ACT, 2'h1, 12'habc);
      op(C_RD, 2'h1, 12'h004);
      cnt = 0;
      repeat (12) begin
        op(C_NOP);
        if (oe === 1'b1) cnt++;
      end
      chk("beats", 12'(1 << n), 12'(cnt));
    end
    // single-write mode: one location per write, later bytes and a masked write leave the array alone
    op(C_PRE, 2'h0, 12'h400);
    op(C_MRS, 2'h0, 12'h202);
    op(C_ACT, 2'h1, 12'habc);
    op(C_WR, 2'h1, 12'h006, 1'b0, 1'b1, 8'h66);
    op(C_NOP, 2'h0, 12'h000, 1'b0, 1'b1, 8'h77);
    op(C_NOP, 2'h0, 12'h000, 1'b0, 1'b1, 8'h88);
    op(C_WR, 2'h1, 12'h007, 1'b1, 1'b1, 8'h99);
    rd(2'h1, 12'h004, 9, 32'ha266_a0a3);
    op(C_ACT, 2'h0, 12'h000);
    op(C_ACT, 2'h2, 12'h000);
    op(C_PRE, 2'h3, 12'h400);
    op(C_NOP);
    chk("open", 12'h000, 12'(bank_open));
    // power-down and self-refresh entry and exit
    op(C_NOP, 2'h0, 12'h000, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
    op(C_ACT, 2'h1, 12'h000, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
    chk("pwr", 12'(PWR_DOWN), 12'(power_mode));
    op(C_NOP);
    op(C_NOP);
    chk("pwr", 12'(PWR_RUN), 12'(power_mode));
    chk("open", 12'h000, 12'(bank_open));
    op(3'h1, 2'h0, 12'h000, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
    op(C_NOP, 2'h0, 12'h000, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
    chk("pwr", 12'(PWR_SELF), 12'(power_mode));
    op(C_NOP);
    op(C_NOP);
    op(C_NOP);
    chk("pwr", 12'(PWR_RUN), 12'(power_mode));
    tally_and_finish();
  end
endmodule : sdp_core_tb
